// [common/hbsh_defines.vh]
// Shared constants for the management-side sideband handshake controller
`ifndef HBSH_DEFINES_VH
`define HBSH_DEFINES_VH

// Register word addresses (Avalon word index)
`define HBSH_ADDR_CTRL    3'h0
`define HBSH_ADDR_STATUS  3'h1
`define HBSH_ADDR_EVENT   3'h2
`define HBSH_ADDR_IDENT   3'h3
`define HBSH_ADDR_GRANTMS 3'h4
`define HBSH_ADDR_RSTUS   3'h5

// Control register fields
`define HBSH_C_GRANT      0
`define HBSH_C_OFFREQ     1
`define HBSH_C_CLKLOCK    2
`define HBSH_C_READY      3
`define HBSH_C_ALTBOOT    4
`define HBSH_C_USERMODE   5
`define HBSH_C_DEBUG      6
`define HBSH_C_WDOFF      7
`define HBSH_C_PWRCAP     8
`define HBSH_C_CARDIRQ    9
`define HBSH_C_FLASHSEL   10
`define HBSH_C_RSTREL     11
`define HBSH_C_PGOOD      12
`define HBSH_CTRL_W       13
`define HBSH_CTRL_RST     13'h0020

// Event register fields (sticky, write one to clear)
`define HBSH_E_TIMEOUT    0
`define HBSH_E_OFFACK     1
`define HBSH_E_RESTART    2
`define HBSH_E_WARN       3
`define HBSH_E_TRIP       4
`define HBSH_E_FAULT      5
`define HBSH_E_BOOTFAIL   6
`define HBSH_E_IMGFAIL    7
`define HBSH_E_BOOTDONE   8
`define HBSH_EVT_W        9

// Timing
`define HBSH_CLK_HZ       20000000
`define HBSH_REQ_LIMIT_MS 500
`define HBSH_RST_HOLD_US  10
// Identity word; the value is arbitrary
`define HBSH_IDENT_VAL    32'h0000_5a5a

`endif

// [rtl/hbsh_sync.v]
// Two-stage synchroniser bank for sideband inputs
`timescale 1ns/10ps
module hbsh_sync #(
    parameter W     = 8,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         clk_i,    // Clock
    input  wire         resetn_i, // Async reset, low
    input  wire [W-1:0] d_i,      // Async inputs
    output wire [W-1:0] q_o       // Synchronised outputs
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : bit_sync
            reg s1_r;
            reg s2_r;
            always @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    s1_r <= INIT[g];
                    s2_r <= INIT[g];
                end
                else
                begin
                    s1_r <= d_i[g];
                    s2_r <= s1_r;
                end
            end
            assign q_o[g] = s2_r;
        end
    endgenerate

endmodule

// [rtl/hbsh_ctrl.v]
// Management-side controller driving the processor sideband pins
`timescale 1ns/10ps
`include "hbsh_defines.vh"
module hbsh_ctrl #(
    parameter integer REQ_LIMIT_CYC =
        (`HBSH_CLK_HZ / 1000) * `HBSH_REQ_LIMIT_MS,
    parameter integer BLINK_CYC = 4000000
) (
    input  wire        clk_i,                  // Clock, 20 MHz
    input  wire        resetn_i,               // Async reset, low
    // Avalon-MM slave
    input  wire [2:0]  avs_address_i,          // Word address
    input  wire        avs_read_i,             // Read strobe
    input  wire        avs_write_i,            // Write strobe
    input  wire [31:0] avs_writedata_i,        // Write data
    input  wire [3:0]  avs_byteenable_i,       // Byte enables
    output reg  [31:0] avs_readdata_o,         // Read data
    output reg         avs_waitrequest_o,      // Wait request
    // From processor
    input  wire        host_flash_request_i,   // Flash request, high
    input  wire        graceful_off_ack_n_i,   // Shutdown ack, low
    input  wire        soft_restart_ack_n_i,   // Reboot ack, low
    input  wire        thermal_warn_n_i,       // High temp, low
    input  wire        thermal_trip_n_i,       // Over temp, low
    input  wire        fault_indicator_n_i,    // Fault alert, low
    input  wire        firmware_boot_done_i,   // Boot done, high
    input  wire        secure_boot_fail_n_i,   // Secure boot fail, low
    input  wire        flash_image_auth_fail_n_i, // Image auth fail
    // To processor
    output reg         mgmt_flash_grant_o,     // Flash grant, high
    output reg         graceful_off_request_n_o, // Shutdown req, low
    output reg         clock_chip_lock_o,      // RTC lock, high
    output reg         mgmt_ready_o,           // Controller ready
    output reg         alt_boot_select_o,      // Special boot
    output reg         user_mode_strap_o,      // User mode, high
    output reg         debug_mode_strap_n_o,   // Debug mode, low
    output reg         watchdog_off_strap_n_o, // Watchdog off, low
    output reg         power_cap_n_o,          // Power limit, low
    output reg         card_present_irq_n_o,   // Card change, low
    output reg         flash_socket_select_o,  // Flash CS mux
    output reg         system_reset_n_o,       // System reset, low
    output reg         socket_power_good_o,    // Power good
    output reg         power_enable_o,         // Board power on
    output reg         red_led_o               // Fault indicator
);

    localparam integer RST_HOLD_CYC =
        (`HBSH_CLK_HZ / 1000000) * `HBSH_RST_HOLD_US;
    localparam [31:0] REQ_LIM = REQ_LIMIT_CYC;
    localparam [31:0] BLINK_LIM = BLINK_CYC;
    localparam [15:0] RST_LIM = RST_HOLD_CYC[15:0];

    // Bus FSM, one-hot
    localparam [2:0] BS_IDLE = 3'b001;
    localparam [2:0] BS_ACK  = 3'b010;
    localparam [2:0] BS_DONE = 3'b100;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire [8:0] raw_w = {
        flash_image_auth_fail_n_i, secure_boot_fail_n_i,
        firmware_boot_done_i, fault_indicator_n_i, thermal_trip_n_i,
        thermal_warn_n_i, soft_restart_ack_n_i, graceful_off_ack_n_i,
        host_flash_request_i};
    wire [8:0] syn_w;

    hbsh_sync #(
        .W    (9),
        .INIT (9'h1be)     // Idle pin levels, no false edge
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (raw_w),
        .q_o      (syn_w)
    );

    wire req_s      = syn_w[0];
    wire offack_s   = ~syn_w[1];
    wire restart_s  = ~syn_w[2];
    wire warn_s     = ~syn_w[3];
    wire trip_s     = ~syn_w[4];
    wire fault_s    = ~syn_w[5];
    wire done_s     = syn_w[6];
    wire bootfail_s = ~syn_w[7];
    wire imgfail_s  = ~syn_w[8];

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [`HBSH_CTRL_W-1:0] ctrl_r;
    reg [`HBSH_EVT_W-1:0]  evt_r;
    reg [`HBSH_EVT_W-1:0]  prev_r;
    reg [31:0]             req_cnt_r;
    reg [15:0]             rst_cnt_r;
    reg                    rst_met_r;
    reg [31:0]             blink_cnt_r;
    reg                    trip_latch_r;
    reg [2:0]              bs_r;

    wire acc_w = (avs_read_i | avs_write_i) & bs_r[0];
    wire timeout_w = req_s && (req_cnt_r >= REQ_LIM - 32'h0000_0001);

    wire [`HBSH_EVT_W-1:0] set_w;
    assign set_w[`HBSH_E_TIMEOUT]  = timeout_w;
    assign set_w[`HBSH_E_OFFACK]   = offack_s;
    assign set_w[`HBSH_E_RESTART]  = restart_s;
    assign set_w[`HBSH_E_WARN]     = warn_s;
    assign set_w[`HBSH_E_TRIP]     = trip_s;
    assign set_w[`HBSH_E_FAULT]    = fault_s;
    assign set_w[`HBSH_E_BOOTFAIL] = bootfail_s;
    assign set_w[`HBSH_E_IMGFAIL]  = imgfail_s;
    assign set_w[`HBSH_E_BOOTDONE] = done_s;

    ////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, answer on the second edge
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bs_r              <= BS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end
        else
        begin
            case (bs_r)
                BS_IDLE:
                begin
                    if (acc_w)
                    begin
                        bs_r              <= BS_ACK;
                        avs_waitrequest_o <= 1'b0;
                        case (avs_address_i)
                            `HBSH_ADDR_CTRL:
                                avs_readdata_o <= {19'h0, ctrl_r};
                            `HBSH_ADDR_STATUS:
                                avs_readdata_o <= {21'h0, trip_latch_r,
                                    rst_met_r, syn_w ^ 9'h1be};
                            `HBSH_ADDR_EVENT:
                                avs_readdata_o <= {23'h0, evt_r};
                            `HBSH_ADDR_IDENT:
                                avs_readdata_o <= `HBSH_IDENT_VAL;
                            `HBSH_ADDR_GRANTMS:
                                avs_readdata_o <= req_cnt_r;
                            `HBSH_ADDR_RSTUS:
                                avs_readdata_o <= {16'h0, rst_cnt_r};
                            default:
                                avs_readdata_o <= 32'h0000_0000;
                        endcase
                    end
                end
                BS_ACK:
                begin
                    bs_r              <= BS_DONE;
                    avs_waitrequest_o <= 1'b1;
                end
                BS_DONE:
                    bs_r <= BS_IDLE;
                default:
                begin
                    bs_r              <= BS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Write lands on the edge where waitrequest is seen low
    wire wr_take_w = avs_write_i & bs_r[1];
    wire [31:0] be_mask_w = {{8{avs_byteenable_i[3]}},
        {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
        {8{avs_byteenable_i[0]}}};
    wire [31:0] wdata_w = avs_writedata_i & be_mask_w;

    ////////////////////////////////////////////////////////////////////
    // Control and sticky events; a set beats a same-cycle clear
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_r <= `HBSH_CTRL_RST;
            evt_r  <= {`HBSH_EVT_W{1'b0}};
            prev_r <= {`HBSH_EVT_W{1'b0}};
        end
        else
        begin
            prev_r <= set_w;
            if (wr_take_w && avs_address_i == `HBSH_ADDR_CTRL)
                ctrl_r <= (ctrl_r & ~be_mask_w[`HBSH_CTRL_W-1:0]) |
                          wdata_w[`HBSH_CTRL_W-1:0];
            if (wr_take_w && avs_address_i == `HBSH_ADDR_EVENT)
                evt_r <= (evt_r & ~wdata_w[`HBSH_EVT_W-1:0]) |
                         (set_w & ~prev_r);
            else
                evt_r <= evt_r | (set_w & ~prev_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request timer: counts while request is held
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            req_cnt_r <= 32'h0000_0000;
        else if (!req_s)
            req_cnt_r <= 32'h0000_0000;
        else if (req_cnt_r < REQ_LIM)
            req_cnt_r <= req_cnt_r + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////
    // Reset hold: release only after minimum low time
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_cnt_r <= 16'h0000;
            rst_met_r <= 1'b0;
        end
        // Count from power good so the hold covers stable rails
        else if (!socket_power_good_o)
        begin
            rst_cnt_r <= 16'h0000;
            rst_met_r <= 1'b0;
        end
        else if (rst_cnt_r >= RST_LIM - 16'h0001)
            rst_met_r <= 1'b1;
        else
            rst_cnt_r <= rst_cnt_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////
    // Fault blink and thermal trip latch
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            blink_cnt_r  <= 32'h0000_0000;
            red_led_o    <= 1'b0;
            trip_latch_r <= 1'b0;
        end
        else
        begin
            if (!fault_s)
            begin
                blink_cnt_r <= 32'h0000_0000;
                red_led_o   <= 1'b0;
            end
            else if (blink_cnt_r >= BLINK_LIM - 32'h0000_0001)
            begin
                blink_cnt_r <= 32'h0000_0000;
                red_led_o   <= ~red_led_o;
            end
            else
                blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
            if (trip_s)
                trip_latch_r <= 1'b1;
            else if (!ctrl_r[`HBSH_C_PGOOD])
                trip_latch_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mgmt_flash_grant_o       <= 1'b0;
            graceful_off_request_n_o <= 1'b1;
            clock_chip_lock_o        <= 1'b0;
            mgmt_ready_o             <= 1'b0;
            alt_boot_select_o        <= 1'b0;
            user_mode_strap_o        <= 1'b1;
            debug_mode_strap_n_o     <= 1'b1;
            watchdog_off_strap_n_o   <= 1'b1;
            power_cap_n_o            <= 1'b1;
            card_present_irq_n_o     <= 1'b1;
            flash_socket_select_o    <= 1'b0;
            system_reset_n_o         <= 1'b0;
            socket_power_good_o      <= 1'b0;
            power_enable_o           <= 1'b0;
        end
        else
        begin
            // Grant raised only while no processor request is live; held once high
            mgmt_flash_grant_o <= ctrl_r[`HBSH_C_GRANT] &
                (~req_s | mgmt_flash_grant_o);
            graceful_off_request_n_o <= ~ctrl_r[`HBSH_C_OFFREQ];
            clock_chip_lock_o  <= ctrl_r[`HBSH_C_CLKLOCK];
            mgmt_ready_o       <= ctrl_r[`HBSH_C_READY];
            alt_boot_select_o  <= ctrl_r[`HBSH_C_ALTBOOT];
            user_mode_strap_o  <= ctrl_r[`HBSH_C_USERMODE];
            debug_mode_strap_n_o <= ~ctrl_r[`HBSH_C_DEBUG];
            watchdog_off_strap_n_o <= ~ctrl_r[`HBSH_C_WDOFF];
            power_cap_n_o      <= ~ctrl_r[`HBSH_C_PWRCAP];
            card_present_irq_n_o <= ~ctrl_r[`HBSH_C_CARDIRQ];
            // Switch chip-select only while processor is off flash
            if (!req_s)
                flash_socket_select_o <= ctrl_r[`HBSH_C_FLASHSEL];
            // Trip overrides software; power drops next edge
            power_enable_o <= ctrl_r[`HBSH_C_PGOOD] & ~trip_s &
                ~trip_latch_r;
            socket_power_good_o <= power_enable_o &
                ctrl_r[`HBSH_C_PGOOD] & ~trip_s;
            system_reset_n_o <= rst_met_r & socket_power_good_o &
                ctrl_r[`HBSH_C_RSTREL] & ~trip_s;
        end
    end

endmodule

// [test/hbsh_ctrl_monitor.sv]
// Port-level concurrent checks for the sideband handshake controller
`timescale 1ns/10ps
module hbsh_ctrl_monitor (
    input wire logic        clk_i,                    // Clock
    input wire logic        resetn_i,                 // Async reset, low
    input wire logic [2:0]  avs_address_i,            // Word address
    input wire logic        avs_read_i,               // Read strobe
    input wire logic        avs_write_i,              // Write strobe
    input wire logic [31:0] avs_writedata_i,          // Write data
    input wire logic [3:0]  avs_byteenable_i,         // Byte enables
    input wire logic [31:0] avs_readdata_o,           // Read data
    input wire logic        avs_waitrequest_o,        // Wait request
    input wire logic        host_flash_request_i,     // Flash request
    input wire logic        thermal_trip_n_i,         // Over temp, low
    input wire logic        fault_indicator_n_i,      // Fault alert, low
    input wire logic        mgmt_flash_grant_o,       // Flash grant
    input wire logic        graceful_off_request_n_o, // Shutdown req
    input wire logic        clock_chip_lock_o,        // Clock lock
    input wire logic        watchdog_off_strap_n_o,   // Watchdog off
    input wire logic        system_reset_n_o,         // System reset
    input wire logic        socket_power_good_o,      // Power good
    input wire logic        power_enable_o,           // Board power
    input wire logic        red_led_o                 // Fault lamp
);
    ////////////////////////////////////////////////////////////////////
    logic [8:0] pe_cnt_r;  // Cycles with board power on, saturating
    wire        ctrl_wr = avs_write_i && !avs_waitrequest_o &&
                          avs_address_i == 3'h0 && avs_byteenable_i == 4'hf;
    wire        rd_ok   = avs_read_i && !avs_waitrequest_o;

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pe_cnt_r <= 9'h000;
        else if (!power_enable_o)
            pe_cnt_r <= 9'h000;
        else if (pe_cnt_r != 9'h1ff)
            pe_cnt_r <= pe_cnt_r + 9'h001;
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        ##[1:3] !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    a_bus_answer: assert property (s_take |-> s_answer)
        else $error("bus access not answered with one-cycle acknowledge");
    a_unmapped_zero: assert property (rd_ok && avs_address_i[2:1] == 2'b11
        |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    a_ident_value: assert property (rd_ok && avs_address_i == 3'h3
        |-> avs_readdata_o == 32'h0000_5a5a)
        else $error("identity register read wrong");
    a_grant_refused: assert property (host_flash_request_i [*5]
        |-> !mgmt_flash_grant_o)
        else $error("grant high while processor holds flash");
    a_strap_follow: assert property (ctrl_wr |-> ##2
        (graceful_off_request_n_o == !$past(avs_writedata_i[1], 2) &&
         clock_chip_lock_o == $past(avs_writedata_i[2], 2) &&
         watchdog_off_strap_n_o == !$past(avs_writedata_i[7], 2)))
        else $error("sideband output does not follow control write");
    a_trip_power_off: assert property (!thermal_trip_n_i [*5]
        |-> !power_enable_o ##1 !socket_power_good_o)
        else $error("power stays on during thermal trip");
    a_pgood_after: assert property ($rose(socket_power_good_o)
        |-> $past(power_enable_o) && power_enable_o)
        else $error("power good before power enable");
    a_reset_hold: assert property ($rose(system_reset_n_o)
        |-> pe_cnt_r >= 9'h0c9 && socket_power_good_o)
        else $error("system reset released too early");
    a_led_quiet: assert property (fault_indicator_n_i [*5]
        |-> !red_led_o)
        else $error("fault lamp lit without fault");
endmodule

bind hbsh_ctrl hbsh_ctrl_monitor mon (.*);

// [test/hbsh_host_model.sv]
// Behavioural processor-side model answering the sideband controller
`timescale 1ns/10ps
module hbsh_host_model (
    input  wire logic       clk_i,        // Clock
    input  wire logic       resetn_i,     // Async reset, low
    input  wire logic       grant_i,      // Controller owns flash
    input  wire logic       off_req_n_i,  // Shutdown request, low
    input  wire logic [7:0] strap_i,      // Straps and lock levels
    input  wire logic       want_flash_i, // Bench asks for flash
    input  wire logic [6:0] alarm_i,      // Bench event commands
    output wire logic [8:0] pins_o        // Processor sideband outputs
);
    logic [1:0] g_s;
    logic [1:0] o_s;
    logic       req_r;
    logic       ack_n_r;
    logic [6:0] al_r;

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            g_s     <= 2'b00;
            o_s     <= 2'b11;
            req_r   <= 1'b0;
            ack_n_r <= 1'b1;
            al_r    <= 7'h00;
        end
        else
        begin
            g_s     <= {g_s[0], grant_i};
            o_s     <= {o_s[0], off_req_n_i};
            // Never starts or keeps a flash access under grant
            req_r   <= want_flash_i && !g_s[1];
            ack_n_r <= o_s[1];
            al_r    <= alarm_i;
        end
    end

    // Firmware-visible modes; no behaviour hangs on them here
    wire rtc_blocked = strap_i[0];
    wire wdog_enable = strap_i[1];
    wire card_irq    = !strap_i[2];
    wire power_limit = !strap_i[3];
    wire alt_boot    = strap_i[4];
    wire user_mode   = strap_i[5];
    wire debug_mode  = !strap_i[6];

    assign pins_o = {~al_r[4], ~al_r[3], al_r[5], ~al_r[2], ~al_r[6],
                     ~al_r[1], ~al_r[0], ack_n_r, req_r};
endmodule

// [test/tb_top.sv]
// Self-checking bench for the sideband handshake controller
`timescale 1ns/10ps
module tb_top;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic [2:0]  av_addr  = 3'h0;
    logic        av_rd    = 1'b0;
    logic        av_wr    = 1'b0;
    logic [31:0] av_wdata = 32'h0000_0000;
    logic [3:0]  av_be    = 4'hf;
    logic        want     = 1'b0;
    logic [6:0]  alarm    = 7'h00;
    logic [31:0] q;
    logic        l0;
    wire  [31:0] av_rdata;
    wire         av_wait;
    wire  [8:0]  pin;
    wire         grant, offreq_n, lock, ready, alt, user, dbg_n, wd_n;
    wire         pcap_n, card_n, fsel, sysrst_n, pgood, pwr_en, led;
    integer      num_errors  = 0;
    integer      check_count = 0;
    integer      tick        = 0;
    integer      i;

    always #25 clk_i = ~clk_i;

    hbsh_ctrl #(.REQ_LIMIT_CYC(50), .BLINK_CYC(8)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(av_addr),
        .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wdata), .avs_byteenable_i(av_be),
        .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
        .host_flash_request_i(pin[0]), .graceful_off_ack_n_i(pin[1]),
        .soft_restart_ack_n_i(pin[2]), .thermal_warn_n_i(pin[3]),
        .thermal_trip_n_i(pin[4]), .fault_indicator_n_i(pin[5]),
        .firmware_boot_done_i(pin[6]), .secure_boot_fail_n_i(pin[7]),
        .flash_image_auth_fail_n_i(pin[8]), .mgmt_flash_grant_o(grant),
        .graceful_off_request_n_o(offreq_n), .clock_chip_lock_o(lock),
        .mgmt_ready_o(ready), .alt_boot_select_o(alt),
        .user_mode_strap_o(user), .debug_mode_strap_n_o(dbg_n),
        .watchdog_off_strap_n_o(wd_n), .power_cap_n_o(pcap_n),
        .card_present_irq_n_o(card_n), .flash_socket_select_o(fsel),
        .system_reset_n_o(sysrst_n), .socket_power_good_o(pgood),
        .power_enable_o(pwr_en), .red_led_o(led));

    hbsh_host_model host (
        .clk_i(clk_i), .resetn_i(resetn_i), .grant_i(grant),
        .off_req_n_i(offreq_n), .want_flash_i(want), .alarm_i(alarm),
        .strap_i({ready, dbg_n, user, alt, pcap_n, card_n, wd_n, lock}),
        .pins_o(pin));

    ////////////////////////////////////////////////////////////////////
    task complete_run;
        begin
            if (num_errors == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk32(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task chk1(input logic got, input logic exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk_i);
    endtask

    // One Avalon access; holds the request until waitrequest is seen low
    task bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
             input logic [3:0] be);
        integer n;
        begin
            @(posedge clk_i);
            av_addr  <= a;
            av_wdata <= d;
            av_be    <= be;
            av_wr    <= wr;
            av_rd    <= !wr;
            n = 0;
            @(posedge clk_i);
            while (av_wait !== 1'b0 && n < 50)
            begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n >= 50)
                num_errors = num_errors + 1;
            q = av_rdata;
            av_wr <= 1'b0;
            av_rd <= 1'b0;
        end
    endtask

    always @(posedge clk_i)
    begin
        tick = tick + 1;
        if (tick == 5000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(6);
        resetn_i <= 1'b1;
        cyc(3);
        chk1(user, 1'b1);
        chk1(dbg_n, 1'b1);
        chk1(sysrst_n, 1'b0);
        bus(0, 3'h0, 32'h0, 4'hf);
        chk32(q, 32'h0000_0020);
        bus(1, 3'h6, 32'hffff_ffff, 4'hf);
        bus(0, 3'h6, 32'h0, 4'hf);
        chk32(q, 32'h0000_0000);
        bus(1, 3'h3, 32'h0, 4'hf);
        bus(0, 3'h3, 32'h0, 4'hf);
        chk32(q, 32'h0000_5a5a);
        for (i = 2; i <= 10; i = i + 1)
        begin
            bus(1, 3'h0, 32'h1 << i, 4'hf);
            cyc(3);
            q = ((32'h1 << i) >> 2) ^ 32'h0000_00f0;
            chk32({23'h0, fsel, card_n, pcap_n, wd_n, dbg_n, user, alt, ready,
                   lock}, q);
        end
        // Lane 0 only: grant, shutdown request and low straps
        bus(1, 3'h2, 32'h0000_01ff, 4'hf);
        bus(1, 3'h0, 32'h0000_ffff, 4'h1);
        bus(0, 3'h0, 32'h0, 4'hf);
        chk32(q, 32'h0000_04ff);
        cyc(12);
        chk1(grant, 1'b1);
        chk1(offreq_n, 1'b0);
        bus(0, 3'h2, 32'h0, 4'hf);
        chk32(q, 32'h0000_0002);
        bus(1, 3'h2, 32'h0000_0002, 4'hf);
        bus(0, 3'h2, 32'h0, 4'hf);
        chk32(q, 32'h0000_0000);
        bus(1, 3'h0, 32'h0000_0020, 4'hf);
        cyc(4);
        want <= 1'b1;
        cyc(8);
        chk1(pin[0], 1'b1);
        bus(1, 3'h0, 32'h0000_0021, 4'hf);
        cyc(4);
        chk1(grant, 1'b0);
        bus(0, 3'h2, 32'h0, 4'hf);
        chk32(q, 32'h0000_0000);
        cyc(40);
        bus(0, 3'h2, 32'h0, 4'hf);
        chk32(q, 32'h0000_0001);
        bus(0, 3'h4, 32'h0, 4'hf);
        chk32(q, 32'h0000_0032);
        want <= 1'b0;
        cyc(8);
        chk1(grant, 1'b1);
        for (i = 0; i < 6; i = i + 1)
        begin
            bus(1, 3'h2, 32'h0000_01ff, 4'hf);
            alarm <= 7'h01 << i;
            cyc(10);
            if (i == 2)
            begin
                l0 = led;
                cyc(8);
                chk1(led, !l0);
            end
            bus(0, 3'h2, 32'h0, 4'hf);
            chk32(q, 32'h1 << (i + 2 + (i > 1)));
            alarm <= 7'h00;
        end
        bus(1, 3'h0, 32'h0000_1020, 4'hf);
        cyc(3);
        chk1(pwr_en, 1'b1);
        chk1(pgood, 1'b1);
        bus(1, 3'h0, 32'h0000_1820, 4'hf);
        cyc(150);
        chk1(sysrst_n, 1'b0);
        cyc(60);
        chk1(sysrst_n, 1'b1);
        bus(0, 3'h1, 32'h0, 4'hf);
        chk32(q & 32'h0000_0200, 32'h0000_0200);
        bus(0, 3'h5, 32'h0, 4'hf);
        chk32(q, 32'h0000_00c7);
        alarm <= 7'h40;
        cyc(8);
        chk1(pwr_en, 1'b0);
        chk1(pgood, 1'b0);
        bus(0, 3'h1, 32'h0, 4'hf);
        chk32(q & 32'h0000_0400, 32'h0000_0400);
        alarm <= 7'h00;
        bus(1, 3'h0, 32'h0000_0020, 4'hf);
        cyc(4);
        complete_run();
    end
endmodule
